// >>> rtl/ers_sequencer.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module ers_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire ers_pkg::ers_bus_s bus,
  output logic [15:0] rdata,
  // Exposure pins
  input wire logic exposure_first,
  input wire logic exposure_second,
  // Converter results
  input wire ers_pkg::ers_word_s [ers_pkg::NCH-1:0] adc_data,
  // Pixel array controls
  output logic pix_reset,
  output logic pix_precharge,
  output logic pix_sample,
  output logic pix_vmem,
  output logic dual_reset,
  // Timing indicator pins
  output logic frame_overhead_pin,
  output logic row_overhead_pin,
  // Serial stream words
  output ers_pkg::ers_stream_s stream
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2:0] ctrl;
  logic [7:0] precharge_duration, sample_duration, vmem_duration, overhead_end_duration;
  logic [7:0] rot_duration, window_kernel_count;
  logic [10:0] y_start, y_end;
  logic [7:0] idle_a, idle_b, test_word, kw_sof, kw_sol, kw_eol;
  ers_pkg::ers_state_e state;
  logic [7:0] cnt;
  logic [10:0] current_line;
  logic integrating, fot_pend, rst_pend;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= 3'h0;
      precharge_duration <= ers_pkg::PRECHARGE_CYC;
      sample_duration <= ers_pkg::SAMPLE_CYC;
      vmem_duration <= ers_pkg::VMEM_CYC;
      overhead_end_duration <= ers_pkg::OVERHEAD_END_CYC;
      rot_duration <= ers_pkg::ROW_OVERHEAD_CYC;
      y_start <= ers_pkg::Y_START_DEF;
      y_end <= ers_pkg::Y_END_DEF;
      window_kernel_count <= ers_pkg::KERNELS_DEF;
      idle_a <= ers_pkg::IDLE_A_DEF;
      idle_b <= ers_pkg::IDLE_B_DEF;
      test_word <= ers_pkg::TEST_DEF;
      kw_sof <= ers_pkg::KW_SOF_DEF;
      kw_sol <= ers_pkg::KW_SOL_DEF;
      kw_eol <= ers_pkg::KW_EOL_DEF;
    end else if (bus.wr) begin
      if (bus.addr == ers_pkg::REG_CTRL) begin
        ctrl <= bus.wdata[2:0];
      end else if (bus.addr == ers_pkg::REG_PRECHARGE) begin
        precharge_duration <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_SAMPLE) begin
        sample_duration <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_VMEM) begin
        vmem_duration <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_OVH_END) begin
        overhead_end_duration <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_ROT) begin
        rot_duration <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_Y_START) begin
        y_start <= bus.wdata[10:0];
      end else if (bus.addr == ers_pkg::REG_Y_END) begin
        y_end <= bus.wdata[10:0];
      end else if (bus.addr == ers_pkg::REG_KERNELS) begin
        window_kernel_count <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_IDLE_A) begin
        idle_a <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_IDLE_B) begin
        idle_b <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_TEST) begin
        test_word <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_KW_SOF) begin
        kw_sof <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_KW_SOL) begin
        kw_sol <= bus.wdata[7:0];
      end else if (bus.addr == ers_pkg::REG_KW_EOL) begin
        kw_eol <= bus.wdata[7:0];
      end
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (!bus.rd) begin
      rdata <= 16'h0000;
    end else if (bus.addr == ers_pkg::REG_CTRL) begin
      rdata <= {13'h0000, ctrl};
    end else if (bus.addr == ers_pkg::REG_PRECHARGE) begin
      rdata <= {8'h00, precharge_duration};
    end else if (bus.addr == ers_pkg::REG_SAMPLE) begin
      rdata <= {8'h00, sample_duration};
    end else if (bus.addr == ers_pkg::REG_VMEM) begin
      rdata <= {8'h00, vmem_duration};
    end else if (bus.addr == ers_pkg::REG_OVH_END) begin
      rdata <= {8'h00, overhead_end_duration};
    end else if (bus.addr == ers_pkg::REG_ROT) begin
      rdata <= {8'h00, rot_duration};
    end else if (bus.addr == ers_pkg::REG_Y_START) begin
      rdata <= {5'h00, y_start};
    end else if (bus.addr == ers_pkg::REG_Y_END) begin
      rdata <= {5'h00, y_end};
    end else if (bus.addr == ers_pkg::REG_KERNELS) begin
      rdata <= {8'h00, window_kernel_count};
    end else if (bus.addr == ers_pkg::REG_IDLE_A) begin
      rdata <= {8'h00, idle_a};
    end else if (bus.addr == ers_pkg::REG_IDLE_B) begin
      rdata <= {8'h00, idle_b};
    end else if (bus.addr == ers_pkg::REG_TEST) begin
      rdata <= {8'h00, test_word};
    end else if (bus.addr == ers_pkg::REG_KW_SOF) begin
      rdata <= {8'h00, kw_sof};
    end else if (bus.addr == ers_pkg::REG_KW_SOL) begin
      rdata <= {8'h00, kw_sol};
    end else if (bus.addr == ers_pkg::REG_KW_EOL) begin
      rdata <= {8'h00, kw_eol};
    end else if (bus.addr == ers_pkg::REG_STATUS) begin
      rdata <= {8'h00, dual_reset, rst_pend, fot_pend, integrating, pix_reset, state};
    end else if (bus.addr == ers_pkg::REG_LINE) begin
      rdata <= {5'h00, current_line};
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Exposure pin synchronisers

  logic [1:0] pin_raw, sync1, sync2, sync3, lvl, lvl_d;
  assign pin_raw = {exposure_second, exposure_first};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        lvl[i] <= 1'b0;
        lvl_d[i] <= 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        lvl[i] <= (sync2[i] == sync3[i]) ? sync3[i] : lvl[i];
        lvl_d[i] <= lvl[i];
      end
    end
  end

  logic exp1_rise, exp1_fall, exp2_rise;
  assign exp1_rise = lvl[0] & ~lvl_d[0];
  assign exp1_fall = ~lvl[0] & lvl_d[0];
  assign exp2_rise = lvl[1] & ~lvl_d[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic reading, line_end, release_rst, last_line;
  assign reading = (state == ers_pkg::ST_ROT) || (state == ers_pkg::ST_KERN);
  assign line_end = (state == ers_pkg::ST_KERN) && (cnt == 8'(window_kernel_count - 8'h01));
  assign last_line = (current_line == y_end);
  // A rise on the last kernel is already at the next row overhead
  assign release_rst = (exp1_rise && (!reading || line_end)) ||
                       (rst_pend && line_end);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ers_pkg::ST_IDLE;
      cnt <= 8'h00;
      current_line <= 11'h000;
    end else begin
      cnt <= cnt + 8'h01;
      case (state)
        ers_pkg::ST_IDLE: begin
          cnt <= 8'h00;
          if (exp1_rise) begin
            state <= ers_pkg::ST_WAIT;
          end
        end
        ers_pkg::ST_WAIT: begin
          cnt <= 8'h00;
          if (exp1_fall) begin
            state <= ers_pkg::ST_FOT;
          end
        end
        ers_pkg::ST_FOT: begin
          if (cnt == 8'(overhead_end_duration - 8'h01)) begin
            state <= ers_pkg::ST_ROT;
            cnt <= 8'h00;
            current_line <= y_start;
          end
        end
        ers_pkg::ST_ROT: begin
          if (cnt == 8'(rot_duration - 8'h01)) begin
            state <= ers_pkg::ST_KERN;
            cnt <= 8'h00;
          end
        end
        ers_pkg::ST_KERN: begin
          if (line_end) begin
            cnt <= 8'h00;
            if (fot_pend || exp1_fall) begin
              state <= ers_pkg::ST_FOT;
            end else if (last_line) begin
              state <= ers_pkg::ST_WAIT;
            end else begin
              state <= ers_pkg::ST_ROT;
              current_line <= current_line + 11'h001;
            end
          end
        end
        default: begin
          state <= ers_pkg::ST_IDLE;
          cnt <= 8'h00;
        end
      endcase
    end
  end

  // Exposure end during readout waits for the line to finish
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fot_pend <= 1'b0;
    end else if (exp1_fall && reading && !line_end) begin
      fot_pend <= 1'b1;
    end else if (state == ers_pkg::ST_FOT) begin
      fot_pend <= 1'b0;
    end
  end

  // Exposure start during a line waits for next row overhead
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_pend <= 1'b0;
    end else if (exp1_rise && reading && !line_end) begin
      rst_pend <= 1'b1;
    end else if (release_rst || !reading) begin
      rst_pend <= 1'b0;
    end
  end

  // Pixel reset re-asserts with the storage voltage rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_reset <= 1'b1;
    end else if (release_rst) begin
      pix_reset <= 1'b0;
    end else if (state == ers_pkg::ST_FOT && cnt == vmem_duration) begin
      pix_reset <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      integrating <= 1'b0;
    end else if (release_rst) begin
      integrating <= 1'b1;
    end else if (state == ers_pkg::ST_FOT && cnt == sample_duration) begin
      integrating <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dual_reset <= 1'b0;
    end else if (!ctrl[ers_pkg::CTRL_DUAL]) begin
      dual_reset <= 1'b0;
    end else if (release_rst) begin
      dual_reset <= 1'b1;
    end else if (exp2_rise) begin
      dual_reset <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame overhead pulses and indicator pins

  logic in_fot;
  assign in_fot = (state == ers_pkg::ST_FOT);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_precharge <= 1'b0;
      pix_sample <= 1'b0;
      pix_vmem <= 1'b1;
      frame_overhead_pin <= 1'b0;
      row_overhead_pin <= 1'b0;
    end else begin
      pix_precharge <= in_fot && (cnt < precharge_duration);
      pix_sample <= in_fot && (cnt < sample_duration);
      pix_vmem <= !(in_fot && (cnt < vmem_duration));
      frame_overhead_pin <= in_fot && (cnt < 8'(overhead_end_duration - 8'h01));
      row_overhead_pin <= (state == ers_pkg::ST_ROT) && (cnt < 8'(rot_duration - 8'h01));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output stream, two words per clock

  logic training, bypass;
  ers_pkg::ers_word_s idle_pair, test_pair;
  assign training = ctrl[ers_pkg::CTRL_TRAIN] && ctrl[ers_pkg::CTRL_BYPASS];
  assign bypass = ctrl[ers_pkg::CTRL_BYPASS];
  assign idle_pair = '{rise: idle_a, fall: idle_b};
  assign test_pair = '{rise: test_word, fall: test_word};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stream.sync <= '0;
    end else if (training) begin
      stream.sync <= idle_pair;
    end else if (state == ers_pkg::ST_ROT && cnt == 8'h00) begin
      stream.sync.rise <= (current_line == y_start) ? kw_sof : kw_sol;
      stream.sync.fall <= idle_b;
    end else if (state == ers_pkg::ST_ROT && cnt == 8'h01) begin
      stream.sync.rise <= {5'h00, current_line[10:8]};
      stream.sync.fall <= current_line[7:0];
    end else if (line_end) begin
      stream.sync.rise <= idle_a;
      stream.sync.fall <= kw_eol;
    end else begin
      stream.sync <= idle_pair;
    end
  end

  for (genvar c = 0; c < ers_pkg::NCH; c++) begin : g_chan
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        stream.data[c] <= '0;
      end else if (training || state != ers_pkg::ST_KERN) begin
        stream.data[c] <= idle_pair;
      end else if (bypass) begin
        stream.data[c] <= test_pair;
      end else begin
        stream.data[c] <= adc_data[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fot_end;
    in_fot && cnt == 8'(overhead_end_duration - 8'h01);
  endsequence

  sequence s_line_done_pending;
    line_end && fot_pend;
  endsequence

  property p_wait_fall_fot;
    (state == ers_pkg::ST_WAIT && exp1_fall) |=> in_fot ##1 frame_overhead_pin;
  endproperty
  a_wait_fall_fot: assert property (p_wait_fall_fot) else $error("no overhead after fall");

  property p_rise_idle_release;
    ((state == ers_pkg::ST_IDLE || state == ers_pkg::ST_WAIT) && exp1_rise) |=>
      !pix_reset && integrating;
  endproperty
  a_rise_idle_release: assert property (p_rise_idle_release) else $error("reset not released");

  property p_rise_line_hold;
    (state == ers_pkg::ST_KERN && exp1_rise && !line_end && pix_reset) |=> pix_reset;
  endproperty
  a_rise_line_hold: assert property (p_rise_line_hold) else $error("reset released mid line");

  property p_pending_to_fot;
    s_line_done_pending |=> in_fot && cnt == 8'h00;
  endproperty
  a_pending_to_fot: assert property (p_pending_to_fot) else $error("line not followed by overhead");

  property p_fot_pin_end;
    s_fot_end |=> !frame_overhead_pin ##1 (state == ers_pkg::ST_ROT) && row_overhead_pin;
  endproperty
  a_fot_pin_end: assert property (p_fot_pin_end) else $error("overhead pin timing");

  property p_sample_ends_int;
    $fell(pix_sample) |-> !integrating && $past(in_fot);
  endproperty
  a_sample_ends_int: assert property (p_sample_ends_int) else $error("integration past sample");

  property p_training_idle;
    training |=> stream.sync == $past(idle_pair) && stream.data[0] == $past(idle_pair);
  endproperty
  a_training_idle: assert property (p_training_idle) else $error("training words wrong");

  property p_test_word;
    (bypass && !training && state == ers_pkg::ST_KERN) |=> stream.data[1].rise == $past(test_word);
  endproperty
  a_test_word: assert property (p_test_word) else $error("test word missing");

  property p_dual_off;
    !ctrl[ers_pkg::CTRL_DUAL] |=> !dual_reset;
  endproperty
  a_dual_off: assert property (p_dual_off) else $error("dual reset while disabled");

  property p_idle_stays;
    (state == ers_pkg::ST_IDLE && !exp1_rise) |=> state == ers_pkg::ST_IDLE;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("left idle without exposure");

  property p_rot_to_kern;
    (state == ers_pkg::ST_ROT && cnt == 8'(rot_duration - 8'h01)) |=> state == ers_pkg::ST_KERN;
  endproperty
  a_rot_to_kern: assert property (p_rot_to_kern) else $error("row overhead length");

  property p_sync_agree;
    $changed(lvl[0]) |-> $past(sync2[0]) == $past(sync3[0]);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("pin level changed unfiltered");

endmodule // ers_sequencer

// >>> rtl/ers_pkg.sv
package ers_pkg;

  // Sensor clock
  localparam int CLK_NS = 100;

  // Frame overhead and row overhead defaults, in ns
  localparam int PRECHARGE_NS = 1500;
  localparam int SAMPLE_NS = 2500;
  localparam int VMEM_NS = 2700;
  localparam int OVERHEAD_END_NS = 3200;
  localparam int ROW_OVERHEAD_NS = 176;

  // Least times round up to whole cycles
  localparam logic [7:0] PRECHARGE_CYC = 8'((PRECHARGE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SAMPLE_CYC = 8'((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] VMEM_CYC = 8'((VMEM_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] OVERHEAD_END_CYC = 8'((OVERHEAD_END_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ROW_OVERHEAD_CYC = 8'((ROW_OVERHEAD_NS + CLK_NS - 1) / CLK_NS);

  // Frame geometry
  localparam int NUM_LINES = 1710;
  localparam int NUM_PIXELS = 1696;
  localparam int KERNEL_PIX = 32;
  localparam logic [7:0] KERNELS_DEF = 8'(NUM_PIXELS / KERNEL_PIX);
  localparam logic [10:0] Y_START_DEF = 11'h000;
  localparam logic [10:0] Y_END_DEF = 11'(NUM_LINES - 1);

  // Stream shape
  localparam int NCH = 32;
  localparam int WW = 8;

  // Register indices
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRECHARGE = 8'h01;
  localparam logic [7:0] REG_SAMPLE = 8'h02;
  localparam logic [7:0] REG_VMEM = 8'h03;
  localparam logic [7:0] REG_OVH_END = 8'h04;
  localparam logic [7:0] REG_ROT = 8'h05;
  localparam logic [7:0] REG_Y_START = 8'h06;
  localparam logic [7:0] REG_Y_END = 8'h07;
  localparam logic [7:0] REG_KERNELS = 8'h08;
  localparam logic [7:0] REG_IDLE_A = 8'h09;
  localparam logic [7:0] REG_IDLE_B = 8'h0a;
  localparam logic [7:0] REG_TEST = 8'h0b;
  localparam logic [7:0] REG_KW_SOF = 8'h0c;
  localparam logic [7:0] REG_KW_SOL = 8'h0d;
  localparam logic [7:0] REG_KW_EOL = 8'h0e;
  localparam logic [7:0] REG_STATUS = 8'h0f;
  localparam logic [7:0] REG_LINE = 8'h10;

  // Control bit positions
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_TRAIN = 1;
  localparam int CTRL_BYPASS = 2;

  // Word reset values
  localparam logic [7:0] IDLE_A_DEF = 8'h55;
  localparam logic [7:0] IDLE_B_DEF = 8'haa;
  localparam logic [7:0] TEST_DEF = 8'h3c;
  localparam logic [7:0] KW_SOF_DEF = 8'hf0;
  localparam logic [7:0] KW_SOL_DEF = 8'he0;
  localparam logic [7:0] KW_EOL_DEF = 8'hd0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_FOT = 3'b010,
    ST_ROT = 3'b011,
    ST_KERN = 3'b100
  } ers_state_e;

  // One word per clock edge
  typedef struct packed {
    logic [WW-1:0] rise;
    logic [WW-1:0] fall;
  } ers_word_s;

  typedef struct packed {
    ers_word_s sync;
    ers_word_s [NCH-1:0] data;
  } ers_stream_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ers_bus_s;

endpackage

// >>> dv/ers_ctrl_model.sv
`timescale 1ns/1ps
module ers_ctrl_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from bench
  input wire logic go,
  input wire logic dual_on,
  // Sensor side
  input wire logic frame_overhead_pin,
  output logic exposure_first,
  output logic exposure_second
);
  logic [4:0] held;

  // Pin level changes only after a full hold
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exposure_first <= 1'b0;
      held <= 5'h00;
    end else if (go != exposure_first && held >= 5'h0f) begin
      exposure_first <= go;
      held <= 5'h00;
    end else if (held != 5'h1f) begin
      held <= held + 5'h01;
    end
  end

  // Second slope opens mid exposure, drops in frame overhead
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      exposure_second <= 1'b0;
    end else if (frame_overhead_pin) begin
      exposure_second <= 1'b0;
    end else if (exposure_first && dual_on && held == 5'h10) begin
      exposure_second <= 1'b1;
    end
  end
endmodule // ers_ctrl_model

// >>> dv/exposure_readout_sequencer_tb.sv
`timescale 1ns/1ps
module exposure_readout_sequencer_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  ers_pkg::ers_bus_s bus = '0;
  logic [15:0] rdata;
  logic go = 1'b0;
  logic dual_on = 1'b0;
  logic exposure_first, exposure_second, pix_reset, pix_precharge, pix_sample, pix_vmem;
  logic dual_reset, frame_overhead_pin, row_overhead_pin;
  ers_pkg::ers_word_s [ers_pkg::NCH-1:0] adc_data = {ers_pkg::NCH{16'h1234}};
  ers_pkg::ers_stream_s stream;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_fot, n_rot, n_smp, n_vmem, n_adc, n_bad, n_test, n_sof, n_eol, n_sync, n_dual, n_pre;
  logic [15:0] v;

  always #50 clk_sys = ~clk_sys;

  ers_sequencer i_ers_sequencer (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .exposure_first(exposure_first), .exposure_second(exposure_second), .adc_data(adc_data),
    .pix_reset(pix_reset), .pix_precharge(pix_precharge), .pix_sample(pix_sample),
    .pix_vmem(pix_vmem), .dual_reset(dual_reset), .frame_overhead_pin(frame_overhead_pin),
    .row_overhead_pin(row_overhead_pin), .stream(stream));

  ers_ctrl_model i_ers_ctrl_model (.clk_sys(clk_sys), .rst(rst), .go(go), .dual_on(dual_on),
    .frame_overhead_pin(frame_overhead_pin), .exposure_first(exposure_first),
    .exposure_second(exposure_second));

  ////////////////////////////////////////////////////////////////
  // Per-frame event counts and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    n_fot += frame_overhead_pin;
    n_rot += row_overhead_pin;
    n_smp += pix_sample;
    n_vmem += !pix_vmem;
    n_dual += dual_reset;
    n_pre += pix_precharge;
    n_adc += (stream.data[5] == 16'h1234);
    n_bad += (stream.data[5] != 16'h1234 && stream.data[5].rise == ers_pkg::TEST_DEF) ? 0 :
      (stream.data[5] != 16'h1234 && stream.data[5] != 16'h55aa);
    n_test += (stream.data[5].rise == ers_pkg::TEST_DEF);
    n_sof += (stream.sync.rise == ers_pkg::KW_SOF_DEF);
    n_eol += (stream.sync.fall == ers_pkg::KW_EOL_DEF);
    n_sync += (stream.sync != 16'h55aa);
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    @(negedge clk_sys);
    v = rdata;
  endtask

  // One exposure then a 160-cycle wait for readout
  task automatic frame;
    @(negedge clk_sys);
    {n_fot, n_rot, n_smp, n_vmem, n_adc, n_bad, n_test, n_sof, n_eol, n_sync, n_dual} = '0;
    n_pre = 0;
    @(posedge clk_sys);
    go <= 1'b1;
    repeat (30) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset released", 16'(pix_reset), 16'h0000);
    repeat (30) @(posedge clk_sys);
    go <= 1'b0;
    repeat (160) @(posedge clk_sys);
    chk("reset again", 16'(pix_reset), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    chk("pix_reset", 16'(pix_reset), 16'h0001);
    chk("pix_vmem", 16'(pix_vmem), 16'h0001);
    chk("sync idle", stream.sync, 16'h55aa);
    rd(8'h05);
    chk("rot", v, 16'h0002);
    rd(8'h04);
    chk("overhead end", v, 16'h0020);
    rd(8'h08);
    chk("kernels", v, 16'h0035);
    rd(8'h07);
    chk("y end", v, 16'h06ad);
    rd(8'h20);
    chk("unmapped", v, 16'h0000);
    rd(8'h0f);
    chk("state", v & 16'h0007, 16'h0000);
  endtask

  task automatic t_normal;
    wr(8'h06, 16'h0001);
    wr(8'h07, 16'h0003);
    wr(8'h08, 16'h0004);
    frame();
    chk("fot pin", 16'(n_fot), 16'h001f);
    chk("sample", 16'(n_smp), 16'h0019);
    chk("precharge", 16'(n_pre), 16'h000f);
    chk("vmem low", 16'(n_vmem), 16'h001b);
    chk("rot pin", 16'(n_rot), 16'h0003);
    chk("adc words", 16'(n_adc), 16'h000c);
    chk("other words", 16'(n_bad), 16'h0000);
    chk("sof", 16'(n_sof), 16'h0001);
    chk("eol", 16'(n_eol), 16'h0003);
    chk("dual off", 16'(n_dual), 16'h0000);
    rd(8'h0f);
    chk("state", v & 16'h0007, 16'h0001);
  endtask

  task automatic t_bypass;
    wr(8'h00, 16'h0004);
    frame();
    chk("test words", 16'(n_test), 16'h000c);
    chk("adc words", 16'(n_adc), 16'h0000);
    chk("sof", 16'(n_sof), 16'h0001);
    chk("fot pin", 16'(n_fot), 16'h001f);
  endtask

  task automatic t_train;
    wr(8'h00, 16'h0006);
    frame();
    chk("sync busy", 16'(n_sync), 16'h0000);
    chk("test words", 16'(n_test), 16'h0000);
    chk("fot pin", 16'(n_fot), 16'h001f);
  endtask

  // Exposure during a long readout: release waits, fall cuts the frame
  task automatic t_pipe;
    wr(8'h00, 16'h0000);
    wr(8'h07, 16'h0040);
    frame();
    frame();
    chk("cut fot pin", 16'(n_fot), 16'h001f);
    chk("cut sof", 16'(n_sof), 16'h0001);
    repeat (300) @(posedge clk_sys);
    rd(8'h0f);
    chk("cut state", v & 16'h0007, 16'h0001);
    wr(8'h07, 16'h0003);
  endtask

  task automatic t_dual;
    wr(8'h00, 16'h0001);
    dual_on <= 1'b1;
    frame();
    chk("dual seen", 16'(n_dual != 0), 16'h0001);
    chk("dual cleared", 16'(dual_reset), 16'h0000);
  endtask

  task automatic report_and_stop;
    $display("TB: errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(negedge clk_sys);
    t_defaults();
    t_normal();
    t_bypass();
    t_train();
    t_pipe();
    t_dual();
    report_and_stop();
  end
endmodule // exposure_readout_sequencer_tb
